// *** hdl/sot_pkg.sv ***
// Package with register map, field layouts and timing for the output timer
package sot_pkg;
  // Register byte offsets
  localparam logic [7:0] SOT_MODE_OFS = 8'h00;
  localparam logic [7:0] SOT_TIME_OFS = 8'h04;
  localparam logic [7:0] SOT_DLY_OFS = 8'h08;
  localparam logic [7:0] SOT_CMD_OFS = 8'h0c;
  localparam logic [7:0] SOT_STAT_OFS = 8'h10;
  // Mode register fields
  localparam int SOT_FUNC_LSB = 0;
  localparam int SOT_WARN_BIT = 2;
  localparam int SOT_RSTRT_BIT = 3;
  localparam int SOT_CFGD_BIT = 4;
  localparam int SOT_MAXN_LSB = 8;
  // Time register fields
  localparam int SOT_SBASE_LSB = 0;
  localparam int SOT_SFAC_LSB = 8;
  localparam int SOT_IBASE_LSB = 16;
  localparam int SOT_IFAC_LSB = 24;
  // Delay register fields
  localparam int SOT_DBASE_LSB = 0;
  localparam int SOT_ONF_LSB = 8;
  localparam int SOT_OFFF_LSB = 16;
  // Command register bits
  localparam int SOT_CMD_VAL_BIT = 0;
  localparam int SOT_CMD_RST_BIT = 1;
  // Reset values and staircase extension cap
  localparam logic [31:0] SOT_MODE_RST = 32'h0000_0100;
  localparam logic [31:0] SOT_TIME_RST = 32'h0101_0101;
  localparam logic [31:0] SOT_DLY_RST = 32'h0001_0100;
  localparam logic [5:0] SOT_MAXN_MAX = 6'h28;
  // Timing in seconds and milliseconds, cycle counts and clock rate
  localparam int SOT_CLK_HZ = 100_000_000;
  localparam int SOT_WARN_OFF_MS = 250;
  localparam int SOT_WARN_ON_S = 30;
  localparam int SOT_UP_S = 240;
  localparam int SOT_TICK_CYC = SOT_CLK_HZ;
  localparam int SOT_WOFF_CYC = SOT_CLK_HZ / 1000 * SOT_WARN_OFF_MS;
  // Timer functions
  typedef enum logic [1:0] {
    SOT_F_SWITCH = 2'h0,
    SOT_F_STAIR = 2'h1,
    SOT_F_IMPULSE = 2'h2,
    SOT_F_DELAY = 2'h3
  } sot_func_type;
  // Bus request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sot_apb_req_type;
endpackage : sot_pkg

// *** hdl/sot_timer.sv ***
// Switching output timer: staircase, impulse, on/off delay, power-up
// What this block does
// - Staircase extensions capped at programmed 1..40
// - Each switch-on while running below the cap adds one staircase period
// - Restart resets accumulated extension count anytime
// - Impulse mode: value one starts pulse
// - Pulse width is base times factor
// - On and off delays share base
// - Separate on/off factors, delay base times factor
// - Recovery restart only in staircase or impulse
// - Unconfigured device defaults to drive mode
// - Unconfigured: upward output on about 4 minutes
// - New parameters apply after both supplies present
// - Staircase period is base times factor
// - Early warning: off 0.25 s, on 30 s
`timescale 1ns/1ps
module sot_timer #(
  parameter int TICK_CYC = sot_pkg::SOT_TICK_CYC,
  parameter int WOFF_CYC = sot_pkg::SOT_WOFF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sw_valid,
  input wire logic sw_value,
  input wire logic bus_ok,
  input wire logic mains_ok,
  input wire logic bus_recover,
  output logic relay_out,
  output logic drive_mode,
  output logic drive_up
);
  // Sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RUN = 5'b00010,
    ST_WOFF = 5'b00100,
    ST_WON = 5'b01000,
    ST_DLY = 5'b10000
  } sot_state_type;

  sot_pkg::sot_apb_req_type req;
  sot_state_type state_q, state_d;
  logic [31:0] mode_q, time_q, dly_q; // Shadow set, written by software
  logic [31:0] amode_q, atime_q, adly_q; // Active set, used by timing
  logic [1:0] bus_s_q, mains_s_q; // Supply synchronisers
  logic both_q; // Both supplies present now, registered one cycle late
  logic pend_q; // Shadow waits for commit
  logic [26:0] pre_q; // One second prescaler
  logic tick;
  logic [19:0] sec_q; // Remaining seconds; wide enough for 40 summed periods
  logic [5:0] ext_q; // Accumulated extension count
  logic [26:0] woff_q; // Warning off cycles
  logic out_q, tgt_q, up_q;
  logic [8:0] up_sec_q;

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign pready = 1'b1; // No wait states
  wire acc = req.psel & req.penable;
  wire wr = acc & req.pwrite;
  wire hit_mode = req.paddr == sot_pkg::SOT_MODE_OFS;
  wire hit_time = req.paddr == sot_pkg::SOT_TIME_OFS;
  wire hit_dly = req.paddr == sot_pkg::SOT_DLY_OFS;
  wire hit_cmd = req.paddr == sot_pkg::SOT_CMD_OFS;
  wire hit_stat = req.paddr == sot_pkg::SOT_STAT_OFS;
  wire mapped = hit_mode | hit_time | hit_dly | hit_cmd | hit_stat;
  assign pslverr = acc & ~mapped; // Unmapped answer is an error

  // Seconds for base code: 1, 10, 30, 60
  function automatic logic [5:0] base_s(input logic [1:0] code);
    unique case (code)
      2'h0: base_s = 6'h01;
      2'h1: base_s = 6'h0a;
      2'h2: base_s = 6'h1e;
      default: base_s = 6'h3c;
    endcase
  endfunction : base_s

  // Period in seconds from base code and factor, factor 0 taken as 1
  function automatic logic [15:0] period(input logic [1:0] b,
                                         input logic [7:0] f);
    logic [7:0] ff;
    ff = (f == 8'h00) ? 8'h01 : f;
    // Widen before multiplying so the product is never cut to 8 bits
    period = 16'(base_s(b)) * 16'(ff);
  endfunction : period

  // Decoded active configuration
  wire cfgd = amode_q[sot_pkg::SOT_CFGD_BIT];
  wire [1:0] func = amode_q[sot_pkg::SOT_FUNC_LSB +: 2];
  wire warn_en = amode_q[sot_pkg::SOT_WARN_BIT];
  wire rstrt_en = amode_q[sot_pkg::SOT_RSTRT_BIT];
  wire [5:0] maxn_raw = amode_q[sot_pkg::SOT_MAXN_LSB +: 6];
  // Out-of-range cap is clamped so the count can never pass 40
  wire [5:0] maxn = (maxn_raw > sot_pkg::SOT_MAXN_MAX) ?
                    sot_pkg::SOT_MAXN_MAX : maxn_raw;
  wire [15:0] stair_p = period(atime_q[sot_pkg::SOT_SBASE_LSB +: 2],
                               atime_q[sot_pkg::SOT_SFAC_LSB +: 8]);
  wire [15:0] imp_p = period(atime_q[sot_pkg::SOT_IBASE_LSB +: 2],
                             atime_q[sot_pkg::SOT_IFAC_LSB +: 8]);
  wire [15:0] on_p = period(adly_q[sot_pkg::SOT_DBASE_LSB +: 2],
                            adly_q[sot_pkg::SOT_ONF_LSB +: 8]);
  wire [15:0] off_p = period(adly_q[sot_pkg::SOT_DBASE_LSB +: 2],
                             adly_q[sot_pkg::SOT_OFFF_LSB +: 8]);
  wire is_stair = func == sot_pkg::SOT_F_STAIR;
  wire is_imp = func == sot_pkg::SOT_F_IMPULSE;
  wire is_dly = func == sot_pkg::SOT_F_DELAY;
  // Software restart of summing sequence
  wire cmd_wr = wr & hit_cmd;
  wire sum_rst = cmd_wr & pwdata[sot_pkg::SOT_CMD_RST_BIT];
  // Switch event from bus or from software
  wire ev = cfgd & (sw_valid | (cmd_wr & ~sum_rst));
  wire ev_val = sw_valid ? sw_value : pwdata[sot_pkg::SOT_CMD_VAL_BIT];
  // Recovery retrigger only for timed functions
  wire retrig = cfgd & bus_recover & rstrt_en & (is_stair | is_imp);
  wire start_on = (ev & ev_val) | retrig;
  wire may_ext = ext_q < maxn;
  wire sec_end = tick & (sec_q == 20'h00001);
  wire sec_dec = tick & (sec_q != 20'h00000); // One second elapsed
  // Extension keeps the tick of its own cycle, so no second is lost
  wire [19:0] sec_ext = sec_q - {19'h0, sec_dec} + 20'(stair_p);
  wire grow = start_on & is_stair & may_ext; // Accepted extension
  // Opposite command in the expiry cycle still cancels the delay
  wire dly_cancel = ev & (ev_val == out_q);

  assign tick = pre_q == 27'(TICK_CYC - 1);

  // Registers and commit: shadow moves to active once supplies coincide
  wire both_now = bus_s_q[1] & mains_s_q[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= sot_pkg::SOT_MODE_RST;
      time_q <= sot_pkg::SOT_TIME_RST;
      dly_q <= sot_pkg::SOT_DLY_RST;
      amode_q <= sot_pkg::SOT_MODE_RST;
      atime_q <= sot_pkg::SOT_TIME_RST;
      adly_q <= sot_pkg::SOT_DLY_RST;
      pend_q <= 1'b0;
      both_q <= 1'b0;
    end else begin
      if (wr & hit_mode) mode_q <= pwdata;
      if (wr & hit_time) time_q <= pwdata;
      if (wr & hit_dly) dly_q <= pwdata;
      both_q <= both_now;
      // A new write restarts the wait; a write wins over commit
      if (wr & (hit_mode | hit_time | hit_dly)) begin
        pend_q <= 1'b1;
      end else if (pend_q & both_now) begin
        amode_q <= mode_q;
        atime_q <= time_q;
        adly_q <= dly_q;
        pend_q <= 1'b0;
      end
    end
  end

  // Read mux
  always_comb begin
    prdata = 32'h0;
    if (hit_mode) prdata = mode_q;
    if (hit_time) prdata = time_q;
    if (hit_dly) prdata = dly_q;
    if (hit_stat) prdata = {16'h0, 2'h0, ext_q, 3'h0, pend_q,
                            both_q, drive_up, tgt_q, out_q};
  end

  // Supply synchronisers and seconds prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_s_q <= 2'h0;
      mains_s_q <= 2'h0;
      pre_q <= 27'h0;
    end else begin
      bus_s_q <= {bus_s_q[0], bus_ok};
      mains_s_q <= {mains_s_q[0], mains_ok};
      pre_q <= tick ? 27'h0 : pre_q + 27'h1;
    end
  end

  // Next state of output sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start_on & (is_stair | is_imp)) state_d = ST_RUN;
        else if (ev & is_dly & (ev_val != out_q)) state_d = ST_DLY;
      ST_RUN: if (ev & ~ev_val) state_d = ST_IDLE;
        else if (grow) state_d = ST_RUN; // Extension outlives expiry
        else if (sec_end & is_stair & warn_en) state_d = ST_WOFF;
        else if (sec_end) state_d = ST_IDLE;
      ST_WOFF: if (woff_q == 27'h1) state_d = ST_WON;
      ST_WON: if (start_on) state_d = ST_RUN;
        else if (sec_end) state_d = ST_IDLE;
      ST_DLY: if (ev & (ev_val == out_q)) state_d = ST_IDLE;
        else if (sec_end) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Sequencer, timers and relay state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      sec_q <= 20'h0;
      ext_q <= 6'h0;
      woff_q <= 27'h0;
      out_q <= 1'b0;
      tgt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (sec_dec) sec_q <= sec_q - 20'h1;
      if (woff_q != 27'h0) woff_q <= woff_q - 27'h1;
      if (!cfgd) out_q <= 1'b0;
      else if (func == sot_pkg::SOT_F_SWITCH) begin
        if (ev) out_q <= ev_val;
      end else if (state_q == ST_IDLE & start_on & is_stair) begin
        sec_q <= 20'(stair_p);
        ext_q <= 6'h1;
        out_q <= 1'b1;
      end else if (state_q == ST_IDLE & start_on & is_imp) begin
        sec_q <= 20'(imp_p);
        out_q <= 1'b1;
      end else if (state_q == ST_IDLE & ev & is_dly & ev_val != out_q) begin
        sec_q <= 20'(ev_val ? on_p : off_p);
        tgt_q <= ev_val;
      end else if (state_q == ST_RUN & ev & ~ev_val) begin
        out_q <= 1'b0;
        sec_q <= 20'h0;
      end else if (state_q == ST_RUN & start_on & is_stair & may_ext) begin
        sec_q <= sec_ext;
        ext_q <= ext_q + 6'h1;
      end else if (state_q == ST_RUN & sec_end & is_stair & warn_en) begin
        out_q <= 1'b0;
        woff_q <= 27'(WOFF_CYC);
      end else if (state_q == ST_RUN & sec_end) begin
        out_q <= 1'b0;
      end else if (state_q == ST_WOFF & woff_q == 27'h1) begin
        out_q <= 1'b1;
        sec_q <= 20'(sot_pkg::SOT_WARN_ON_S);
      end else if (state_q == ST_WON & start_on) begin
        sec_q <= 20'(stair_p);
        ext_q <= 6'h1;
      end else if (state_q == ST_WON & sec_end) begin
        out_q <= 1'b0;
      end else if (state_q == ST_DLY & sec_end & ~dly_cancel) begin
        out_q <= tgt_q;
      end
      // Restart command wins: count begins afresh
      if (sum_rst) ext_q <= 6'h0;
    end
  end

  // Unconfigured power-up: drive mode, upward output for four minutes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q <= 1'b1;
      up_sec_q <= 9'(sot_pkg::SOT_UP_S);
    end else begin
      if (cfgd | (up_sec_q == 9'h0)) up_q <= 1'b0;
      if (tick & (up_sec_q != 9'h0)) up_sec_q <= up_sec_q - 9'h1;
    end
  end

  assign drive_mode = ~cfgd;
  assign drive_up = up_q & ~cfgd;
  assign relay_out = out_q;

  // Checks
  // Refused extension leaves the count where it was
  ext_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_RUN && start_on && is_stair && !may_ext && !sum_rst)
      |=> ext_q == $past(ext_q) && ext_q <= sot_pkg::SOT_MAXN_MAX)
    else $error("extension beyond cap");
  sum_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    sum_rst |=> ext_q == 6'h0) else $error("restart did not clear");
  imp_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_IDLE && cfgd && is_imp && sw_valid && sw_value)
      |=> relay_out && sec_q == 20'(imp_p)) else $error("impulse not started");
  // Expiry with no actuation in the same cycle
  sequence warn_off_s;
    state_q == ST_RUN && sec_end && is_stair && warn_en && !ev && !start_on;
  endsequence
  warn_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    warn_off_s |=> !relay_out && woff_q == 27'(WOFF_CYC))
    else $error("warning off step wrong");
  warn_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_WOFF && woff_q == 27'h1)
      |=> relay_out && sec_q == 20'(sot_pkg::SOT_WARN_ON_S))
    else $error("warning on step wrong");
  dly_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == ST_DLY) |-> sec_q == 20'(tgt_q ? on_p : off_p))
    else $error("delay length wrong");
  dly_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_DLY && sec_end && !ev) |=> relay_out == tgt_q)
    else $error("delay not applied");
  retrig_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_IDLE && bus_recover && !is_stair && !is_imp && !ev)
      |=> state_q != ST_RUN) else $error("retrigger outside timers");
  hold_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
    !both_now |=> $stable(amode_q)) else $error("commit without supply");
  // Relay is registered, so it follows one cycle after the mode
  drive_def_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cfgd |-> drive_mode ##1 !relay_out) else $error("not drive mode");
endmodule : sot_timer

// *** testbench/sot_bus_model.sv ***
// Installation bus model issuing switch and recovery telegrams
`timescale 1ns/1ps
module sot_bus_model (
  input wire logic pclk,
  output logic sw_valid,
  output logic sw_value,
  output logic bus_recover
);
  // Quiet bus at time zero
  initial begin
    sw_valid = 1'b0;
    sw_value = 1'b0;
    bus_recover = 1'b0;
  end
  // One-cycle telegram; value inverted after release so stale data is seen
  task automatic send(input logic v);
    @(posedge pclk);
    sw_valid <= 1'b1;
    sw_value <= v;
    @(posedge pclk);
    sw_valid <= 1'b0;
    sw_value <= ~v;
  endtask : send
  // One-cycle bus voltage recovery pulse
  task automatic recover();
    @(posedge pclk);
    bus_recover <= 1'b1;
    @(posedge pclk);
    bus_recover <= 1'b0;
  endtask : recover
endmodule : sot_bus_model

// *** testbench/tb.sv ***
// Self-checking bench for the switching output timer
`timescale 1ns/1ps
`define CHK(a, b) begin if ((a) !== (b)) begin \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); \
  err_count++; end compares++; end
module tb;
  logic pclk = 1'b0; // 100 MHz clock
  logic presetn; // Active-low reset
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sw_valid;
  logic sw_value;
  logic bus_recover;
  logic bus_ok; // Supplies as levels
  logic mains_ok;
  logic relay_out;
  logic drive_mode;
  logic drive_up;
  logic [31:0] rd; // Last read data
  logic er; // Last error response
  logic ok; // Result of a timing window check
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  // Clock
  always #5 pclk = ~pclk;
  // Far side telegram source
  sot_bus_model bus_i (.pclk(pclk), .sw_valid(sw_valid),
    .sw_value(sw_value), .bus_recover(bus_recover));
  // Short tick so periods stay in tens of cycles
  sot_timer #(.TICK_CYC(10), .WOFF_CYC(3)) sot_timer_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sw_valid(sw_valid), .sw_value(sw_value),
    .bus_ok(bus_ok), .mains_ok(mains_ok), .bus_recover(bus_recover),
    .relay_out(relay_out), .drive_mode(drive_mode), .drive_up(drive_up));
  // Verdict and end of run
  task automatic end_sim();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the hang guard ends a wait on a silent slave
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Load all parameters, then let the commit land
  task automatic cfg(input logic [31:0] m, input logic [31:0] t,
                     input logic [31:0] d);
    apb(1'b1, sot_pkg::SOT_TIME_OFS, t);
    apb(1'b1, sot_pkg::SOT_DLY_OFS, d);
    apb(1'b1, sot_pkg::SOT_MODE_OFS, m);
    repeat (10) @(posedge pclk);
  endtask : cfg
  // Count cycles the relay keeps a level; ok when within lo..hi
  task automatic hold(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (relay_out === lvl && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    ok = (n >= lo && n <= hi);
  endtask : hold
  // Reset values and unconfigured power-up drive
  task automatic t_unconf();
    `CHK(drive_mode, 1'b1)
    `CHK(drive_up, 1'b1)
    apb(1'b0, sot_pkg::SOT_MODE_OFS, 32'h0);
    `CHK(rd, sot_pkg::SOT_MODE_RST)
    apb(1'b0, sot_pkg::SOT_TIME_OFS, 32'h0);
    `CHK(rd, sot_pkg::SOT_TIME_RST)
    apb(1'b0, sot_pkg::SOT_DLY_OFS, 32'h0);
    `CHK(rd, sot_pkg::SOT_DLY_RST)
    repeat (2280) @(posedge pclk);
    `CHK(drive_up, 1'b1)
    repeat (200) @(posedge pclk);
    `CHK(drive_up, 1'b0)
  endtask : t_unconf
  // Parameters wait for both supplies; unmapped access refused
  task automatic t_commit();
    apb(1'b1, sot_pkg::SOT_MODE_OFS, 32'h0000_0218);
    repeat (10) @(posedge pclk);
    `CHK(drive_mode, 1'b1)
    apb(1'b0, sot_pkg::SOT_STAT_OFS, 32'h0);
    `CHK(rd[4], 1'b1)
    mains_ok <= 1'b1; // Mains arrives as bus drops: still no overlap
    bus_ok <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK(drive_mode, 1'b1)
    bus_ok <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK(drive_mode, 1'b0)
    apb(1'b0, 8'h14, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    bus_i.recover();
    repeat (20) @(posedge pclk);
    `CHK(relay_out, 1'b0)
  endtask : t_commit
  // Impulse width, base 1 s factor 3, also retriggered by recovery
  task automatic t_impulse();
    cfg(32'h0000_011a, 32'h0300_0000, sot_pkg::SOT_DLY_RST);
    bus_i.send(1'b1);
    hold(1'b0, 0, 5);
    hold(1'b1, 20, 32);
    `CHK(ok, 1'b1)
    bus_i.recover();
    hold(1'b0, 0, 5);
    hold(1'b1, 20, 32);
    `CHK(ok, 1'b1)
  endtask : t_impulse
  // Staircase summing capped at two periods, then restart
  task automatic t_stair();
    cfg(32'h0000_0211, 32'h0000_0200, sot_pkg::SOT_DLY_RST);
    repeat (3) bus_i.send(1'b1);
    apb(1'b0, sot_pkg::SOT_STAT_OFS, 32'h0);
    `CHK(rd[13:8], 6'h02)
    hold(1'b1, 22, 40);
    `CHK(ok, 1'b1)
    repeat (2) bus_i.send(1'b1);
    apb(1'b1, sot_pkg::SOT_CMD_OFS, 32'h0000_0002);
    apb(1'b0, sot_pkg::SOT_STAT_OFS, 32'h0);
    `CHK(rd[13:8], 6'h00)
    `CHK(relay_out, 1'b1)
    hold(1'b1, 0, 60);
  endtask : t_stair
  // Early warning after expiry: brief off, then 30 s on
  task automatic t_warn();
    cfg(32'h0000_0115, 32'h0000_0100, sot_pkg::SOT_DLY_RST);
    bus_i.send(1'b1);
    hold(1'b0, 0, 5);
    hold(1'b1, 0, 14);
    hold(1'b0, 2, 5);
    `CHK(ok, 1'b1)
    hold(1'b1, 291, 300); // 30 ticks, less the phase of the first
    `CHK(ok, 1'b1)
  endtask : t_warn
  // On delay 2 ticks, off delay 4 ticks, opposite command cancels
  task automatic t_delay();
    cfg(32'h0000_0113, 32'h0000_0100, 32'h0004_0200);
    bus_i.send(1'b1);
    hold(1'b0, 9, 23);
    `CHK(ok, 1'b1)
    bus_i.send(1'b0);
    hold(1'b1, 29, 43);
    `CHK(ok, 1'b1)
    bus_i.send(1'b1);
    repeat (4) @(posedge pclk);
    bus_i.send(1'b0);
    repeat (40) @(posedge pclk);
    `CHK(relay_out, 1'b0)
    // Software switch value takes the same on delay
    apb(1'b1, sot_pkg::SOT_CMD_OFS, 32'h0000_0001);
    hold(1'b0, 9, 23);
    `CHK(ok, 1'b1)
  endtask : t_delay
  // Main sequence
  initial begin
    // Idle bus, bus supply only, reset asserted
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    bus_ok <= 1'b1;
    mains_ok <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_unconf();
    t_commit();
    t_impulse();
    t_stair();
    t_warn();
    t_delay();
    end_sim();
  end
endmodule : tb
